/* File: rtl/gport_cmd_ctrl.sv */
// Graphics port command register bank with its request gating.
// Assumes an AXI4-Lite master for configuration software and a port
// master whose pins arrive asynchronously to aclk.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gport_consts.svh"

module gport_cmd_ctrl (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [`GP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [`GP_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port master pins: request strobe, side-band frame, done strobe
	input wire logic pipe_req,
	input wire logic sba_cmd,
	input wire logic svc_done,
	// Toward the request queue and transfer logic
	output logic pipe_accept,
	output logic sba_accept,
	output logic svc_busy,
	output logic xfer_rate_1x,
	output logic xfer_rate_2x
);
	import gport_pkg::*;

	// ------------------------------------------------------------------
	// Command register and pin synchronisation
	// ------------------------------------------------------------------
	logic [31:0] command_reg;
	logic [`GP_SYNC_W-1:0] pin_lvl;
	logic [`GP_SYNC_W-1:0] pin_prev_reg;
	logic port_en;
	logic sba_en;

	assign port_en = command_reg[`GP_CMD_PORT_EN];
	assign sba_en = command_reg[`GP_CMD_SBA_EN];

	gport_in_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in({svc_done, sba_cmd, pipe_req}),
		.level_out(pin_lvl)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_prev_reg <= '0;
		end else begin
			pin_prev_reg <= pin_lvl;
		end
	end

	logic pipe_rise;
	logic sba_rise;
	logic sba_fall;
	logic done_rise;
	assign pipe_rise = pin_lvl[0] & ~pin_prev_reg[0];
	assign sba_rise = pin_lvl[1] & ~pin_prev_reg[1];
	assign sba_fall = ~pin_lvl[1] & pin_prev_reg[1];
	assign done_rise = pin_lvl[2] & ~pin_prev_reg[2];

	// ------------------------------------------------------------------
	// Request gating
	// ------------------------------------------------------------------
	logic sba_flight_reg;
	logic sba_rate1x_reg;
	logic [`GP_PEND_W-1:0] pend_reg;
	logic pipe_take;
	logic sba_take;

	// Pipe requests need only the port enable
	assign pipe_take = pipe_rise & port_en;

	// Side-band frame is judged at its end; at 1X a frame begun while
	// enabled survives a mid-frame disable, at 2X enables must still hold
	assign sba_take = sba_fall & sba_flight_reg &
		(sba_rate1x_reg | (port_en & sba_en));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sba_flight_reg <= 1'b0;
			sba_rate1x_reg <= 1'b0;
		end else if (sba_rise) begin
			sba_flight_reg <= port_en & sba_en;
			sba_rate1x_reg <= command_reg[`GP_CMD_RATE_1X];
		end else if (sba_fall) begin
			sba_flight_reg <= 1'b0;
			sba_rate1x_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pipe_accept <= 1'b0;
			sba_accept <= 1'b0;
		end else begin
			pipe_accept <= pipe_take;
			sba_accept <= sba_take;
		end
	end

	// Queued work is counted regardless of the enable, so disabling the
	// port never strands an accepted request
	logic take_any;
	logic done_ok;
	assign take_any = pipe_take | sba_take;
	assign done_ok = done_rise & (pend_reg != '0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_reg <= '0;
		end else if (take_any & ~done_ok & ~(&pend_reg)) begin
			pend_reg <= pend_reg + `GP_PEND_W'(1);
		end else if (done_ok & ~take_any) begin
			pend_reg <= pend_reg - `GP_PEND_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			svc_busy <= 1'b0;
		end else begin
			svc_busy <= (pend_reg != '0) | take_any;
		end
	end

	// One rate drives both buses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xfer_rate_1x <= 1'b0;
			xfer_rate_2x <= 1'b0;
		end else begin
			xfer_rate_1x <= command_reg[`GP_CMD_RATE_1X];
			xfer_rate_2x <= command_reg[`GP_CMD_RATE_2X];
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------
	wr_state_t wr_state_reg;
	logic [`GP_ADDR_W-1:0] awaddr_reg;
	logic aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic w_held_reg;
	logic [31:0] wr_bytemask;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end else if (wr_state_reg == WR_RESP && s_axi_bready) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end else if (wr_state_reg == WR_RESP && s_axi_bready) begin
			w_held_reg <= 1'b0;
		end
	end

	// Ready only while idle and the slot is empty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= wr_state_reg == WR_IDLE && !aw_held_reg &&
				!(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= wr_state_reg == WR_IDLE && !w_held_reg &&
				!(s_axi_wvalid & s_axi_wready);
		end
	end

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			assign wr_bytemask[8*b +: 8] = {8{wstrb_reg[b]}};
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wr_state_reg)
			WR_IDLE: begin
				if (aw_held_reg & w_held_reg) begin
					wr_state_reg <= WR_RESP;
					s_axi_bvalid <= 1'b1;
					s_axi_bresp <= (awaddr_reg[`GP_ADDR_W-1:2] ==
						`GP_OFS_COMMAND >> 2) ? RESP_OKAY : RESP_SLVERR;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_reg <= WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			end
			default: begin
				wr_state_reg <= WR_IDLE;
				s_axi_bvalid <= 1'b0;
			end
			endcase
		end
	end

	// Reserved bits masked off; only the command word is writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			command_reg <= `GP_CMD_RESET;
		end else if (wr_state_reg == WR_IDLE && aw_held_reg &&
			w_held_reg && awaddr_reg[`GP_ADDR_W-1:2] ==
			`GP_OFS_COMMAND >> 2) begin
			command_reg <= (command_reg & ~(wr_bytemask & `GP_CMD_WMASK)) |
				(wdata_reg & wr_bytemask & `GP_CMD_WMASK);
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------
	logic [31:0] rd_word;
	logic rd_hit;

	always_comb begin
		rd_word = '0;
		rd_hit = 1'b1;
		case ({s_axi_araddr[`GP_ADDR_W-1:2], 2'b00})
		`GP_OFS_STATUS: rd_word = `GP_STATUS_VALUE;
		`GP_OFS_COMMAND: rd_word = command_reg;
		`GP_OFS_STATE: begin
			rd_word[`GP_PEND_W-1:0] = pend_reg;
			rd_word[`GP_ST_SBA_FLIGHT] = sba_flight_reg;
			rd_word[`GP_ST_SVC_BUSY] = svc_busy;
		end
		default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule : gport_cmd_ctrl

`default_nettype wire

/* File: rtl/gport_consts.svh */
// Offsets, field positions and reset values of the graphics port command logic.
// Included by the package and the design modules; holds definitions only.
`ifndef GPORT_CONSTS_SVH
`define GPORT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define GP_ADDR_W 8
`define GP_OFS_STATUS 8'hA4
`define GP_OFS_COMMAND 8'hA8
`define GP_OFS_STATE 8'hAC

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define GP_CMD_RATE_1X 0
`define GP_CMD_RATE_2X 1
`define GP_CMD_PORT_EN 8
`define GP_CMD_SBA_EN 9
`define GP_CMD_RESET 32'h00000000
`define GP_CMD_WMASK 32'h00000303

// ----------------------------------------------------------------------
// Read-only capability word: side-band plus both rates
// ----------------------------------------------------------------------
`define GP_STATUS_VALUE 32'h00000203

// ----------------------------------------------------------------------
// State register fields
// ----------------------------------------------------------------------
`define GP_PEND_W 6
`define GP_ST_SBA_FLIGHT 8
`define GP_ST_SVC_BUSY 9

// ----------------------------------------------------------------------
// Input synchroniser
// ----------------------------------------------------------------------
`define GP_SYNC_W 3

`endif

/* File: rtl/gport_pkg.sv */
// Types shared by the graphics port command logic.
// Assumes gport_consts.svh is on the include path.
`include "gport_consts.svh"

package gport_pkg;

	typedef enum logic [1:0] {
		RESP_OKAY = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_t;

endpackage : gport_pkg

/* File: rtl/gport_in_sync.sv */
// Three-stage synchroniser for pins arriving from the port master.
// Assumes a single clock aclk; the output changes once stages two and
// three agree.
`timescale 1ns/1ps
`default_nettype none
`include "gport_consts.svh"

module gport_in_sync (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pin levels in and filtered levels out
	input wire logic [`GP_SYNC_W-1:0] pin_in,
	output logic [`GP_SYNC_W-1:0] level_out
);
	import gport_pkg::*;

	genvar i;
	generate
		for (i = 0; i < `GP_SYNC_W; i = i + 1) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic lvl_reg;

			// s1 feeds s2 only: metastability guard
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
				end else begin
					s1_reg <= pin_in[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					lvl_reg <= 1'b0;
				end else if (s2_reg == s3_reg) begin
					lvl_reg <= s3_reg;
				end
			end

			assign level_out[i] = lvl_reg;
		end
	endgenerate

endmodule : gport_in_sync

`default_nettype wire

/* File: dv/gport_cmd_ctrl_chk.sv */
// Checker for the command logic bus handshakes and port accept timing.
// Assumes it is bound into gport_cmd_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module gport_cmd_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port side
	input wire logic svc_done,
	input wire logic pipe_accept,
	input wire logic sba_accept,
	input wire logic svc_busy
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ----
	// Steps
	// ----
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Eight quiet cycles outlast the synchroniser delay of any done rise
	sequence done_quiet;
		(!svc_done)[*8];
	endsequence

	a_wr_resp_time: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after take");
	a_wr_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
		else $error("write channel not reopened after response");
	a_wr_blocked: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write ready during response");
	a_resp_code: assert property (s_axi_bvalid |->
		s_axi_bresp inside {2'h0, 2'h2})
		else $error("illegal write response code");
	a_rd_resp_next: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after take");
	a_rd_reopen: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened");
	a_pipe_pulse: assert property (pipe_accept |=> !pipe_accept)
		else $error("pipe accept longer than one cycle");
	a_sba_pulse: assert property (sba_accept |=> !sba_accept)
		else $error("side-band accept longer than one cycle");
	a_accept_busy: assert property (pipe_accept || sba_accept |-> svc_busy)
		else $error("accept without busy");
	a_busy_kept: assert property (done_quiet ##1 svc_busy |=> svc_busy)
		else $error("busy dropped without done");
	a_reset_idle: assert property (disable iff (1'h0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !svc_busy && !pipe_accept)
		else $error("outputs active after reset edge");
endmodule : gport_cmd_chk
`default_nettype wire

/* File: dv/gport_master_model.sv */
// Port master model: request, side-band frame and done pins.
// Assumes the bench calls its tasks; pins change just after aclk rises.
`timescale 1ns/1ps
`default_nettype none

module gport_master_model (
	// Clock
	input wire logic aclk,
	// Pins toward the target
	output logic pipe_req,
	output logic sba_cmd,
	output logic svc_done
);
	// Master capability, read by software before the rate is chosen
	logic [1:0] cap_rate = 2'h3;
	logic [1:0] rate_sel = 2'h0;

	initial begin
		pipe_req = 1'h0;
		sba_cmd = 1'h0;
		svc_done = 1'h0;
	end

	// Five cycles a level, above what the synchroniser needs
	task automatic pipe;
		@(posedge aclk);
		pipe_req <= 1'h1;
		repeat (5) @(posedge aclk);
		pipe_req <= 1'h0;
		repeat (5) @(posedge aclk);
	endtask : pipe
	task automatic done;
		@(posedge aclk);
		svc_done <= 1'h1;
		repeat (5) @(posedge aclk);
		svc_done <= 1'h0;
		repeat (5) @(posedge aclk);
	endtask : done
	task automatic frame(input logic on);
		@(posedge aclk);
		sba_cmd <= on;
		repeat (5) @(posedge aclk);
	endtask : frame
endmodule : gport_master_model
`default_nettype wire

/* File: dv/graphics_port_command_ctrl_tb.sv */
// Bench: register access, port gating and outstanding tracking.
// Assumes rtl files, checker and master model compile before it.
`timescale 1ns/1ps
`default_nettype none
`include "gport_consts.svh"

module graphics_port_command_ctrl_tb import gport_pkg::*; ;
	logic aclk, aresetn = 1'h0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, lf = 8'h3E;
	logic [31:0] wdata = 32'h0, rdata, shadow = 32'h0, got;
	logic [3:0] wstrb = 4'h0;
	logic [2:0] prot = 3'h0;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic awr, wrdy, bv, arr, rv, pipe_req, sba_cmd, svc_done;
	logic pa, sa, busy, r1, r2;
	logic [1:0] bresp, rresp, resp;
	int errors = 0, cmp_count = 0, cyc = 0, npa = 0, nsa = 0;

	gport_cmd_ctrl u_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
		.s_axi_arprot(prot), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .pipe_req(pipe_req), .sba_cmd(sba_cmd),
		.svc_done(svc_done), .pipe_accept(pa), .sba_accept(sa),
		.svc_busy(busy), .xfer_rate_1x(r1), .xfer_rate_2x(r2));
	gport_master_model u_m (.aclk(aclk), .pipe_req(pipe_req),
		.sba_cmd(sba_cmd), .svc_done(svc_done));

	initial begin
		aclk = 1'h0;
		forever #4 aclk = ~aclk;
	end
	// Cycle ceiling well above the few hundred the tests need
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (pa === 1'h1) npa <= npa + 1;
		if (sa === 1'h1) nsa <= nsa + 1;
		if (cyc == 8000) begin
			errors = errors + 1;
			complete_run();
		end
	end

	// ----
	// Helpers
	// ----
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nx
	function automatic logic [31:0] exp_cmd(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = `GP_CMD_WMASK & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (o & ~m) | (d & m);
	endfunction : exp_cmd
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			errors++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		prot <= lf[2:0];
		wdata <= d;
		wstrb <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do begin
			@(posedge aclk);
			if (awv && awr) awv <= 1'h0;
			if (wv && wrdy) wv <= 1'h0;
		end while (bv !== 1'h1);
		resp = bresp;
		br <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge aclk);
			if (arv && arr) arv <= 1'h0;
		end while (rv !== 1'h1);
		got = rdata;
		resp = rresp;
		rr <= 1'h0;
	endtask : rd
	task automatic wc(input logic [31:0] d, input logic [3:0] s);
		wr(`GP_OFS_COMMAND, d, s);
		chk(resp, RESP_OKAY);
		shadow = exp_cmd(shadow, d, s);
		rd(`GP_OFS_COMMAND);
		chk(got, shadow);
	endtask : wc
	task automatic sba_frame_gap;
		u_m.frame(1'h1);
		u_m.frame(1'h0);
		repeat (6) @(posedge aclk);
	endtask : sba_frame_gap
	task complete_run();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// ----
	// Scenarios
	// ----
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`GP_OFS_COMMAND);
		chk(got, 32'h00000000);
		chk({r2, r1}, 2'h0);
		rd(`GP_OFS_STATUS);
		chk(got, 32'h00000203);
		wr(`GP_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
		chk(resp, RESP_SLVERR);
		rd(8'hB0);
		chk({got, resp}, {32'h0, RESP_SLVERR});
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			wc({lf, ~lf, nx(lf), lf}, lf[3:0]);
		end
		wc(32'h0, 4'hF);
		u_m.pipe();
		chk(npa, 0);
		wc(32'h00000201, 4'hF);
		sba_frame_gap();
		chk(nsa, 0);
		// Rate chosen from what the master reports it can do
		if (u_m.cap_rate[0]) u_m.rate_sel = 2'h1;
		wc(32'h00000101, 4'hF);
		u_m.pipe();
		chk(npa, 1);
		chk({r2, r1}, u_m.rate_sel);
		sba_frame_gap();
		chk(nsa, 0);
		wc(32'h00000301, 4'hF);
		sba_frame_gap();
		chk(nsa, 1);
		u_m.frame(1'h1);
		wc(32'h00000001, 4'hF);
		u_m.frame(1'h0);
		repeat (6) @(posedge aclk);
		chk(nsa, 2);
		chk(busy, 1'h1);
		wc(32'h00000302, 4'hF);
		u_m.frame(1'h1);
		wc(32'h00000002, 4'hF);
		u_m.frame(1'h0);
		repeat (6) @(posedge aclk);
		chk(nsa, 2);
		chk(r2, 1'h1);
		repeat (3) u_m.done();
		chk(busy, 1'h0);
		complete_run();
	end
endmodule : graphics_port_command_ctrl_tb

bind gport_cmd_ctrl gport_cmd_chk u_chk (.*);
`default_nettype wire
